// ---- hw/bds_pkg.sv ----
package bds_pkg;
	localparam int          CLK_NS      = 50;
	localparam int          MS_NS       = 1000000;
	localparam int          MS_CYCLES   = MS_NS / CLK_NS;
	localparam logic [9:0]  MS_LAST     = 10'h3E7;
	localparam logic [5:0]  SIXTY_LAST  = 6'h3B;
	localparam logic [13:0] IVL_STEP_MS = 14'h0064;
	localparam logic [13:0] IVL_5S_MS   = 14'h1388;
	localparam logic [13:0] IVL_10S_MS  = 14'h2710;
	localparam logic [3:0]  IVL_CODE_1S = 4'h9;
	localparam logic [3:0]  IVL_CODE_5S = 4'hA;
	localparam logic [15:0] MAS_PER_CAH = 16'h8CA0;

	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_STAT = 8'h04;
	localparam logic [7:0] A_SECS = 8'h08;
	localparam logic [7:0] A_HMS  = 8'h0C;
	localparam logic [7:0] A_CAPL = 8'h10;
	localparam logic [7:0] A_CAPH = 8'h14;
	localparam logic [7:0] A_ENGL = 8'h18;
	localparam logic [7:0] A_ENGH = 8'h1C;
	localparam logic [2:0] A_CFG_TAG = 3'h2;
	localparam logic [3:0] SEL_ALL = 4'hF;

	localparam int CTRL_START = 0;
	localparam int CTRL_STOP  = 1;
	localparam int CTRL_ARM   = 2;
	localparam int CTRL_MODE  = 4;

	localparam logic [2:0] CFG_THR  = 3'h1;
	localparam logic [2:0] CFG_TLIM = 3'h2;
	localparam logic [2:0] CFG_CLIM = 3'h3;
	localparam logic [2:0] CFG_ACT  = 3'h4;
	localparam int ACT_TIME_LSB = 0;
	localparam int ACT_CAP_LSB  = 2;
	localparam int ACT_LOG      = 4;
	localparam int ACT_IVL_LSB  = 8;

	localparam logic RST_ARMED = 1'b1;

	typedef enum logic [1:0] {
		LIM_NONE               = 2'h0,
		LIM_SIGNAL             = 2'h1,
		LIMIT_ACTION_TERMINATE = 2'h2
	} bds_action_t;

	typedef enum logic [1:0] {
		CONSTANT_CURRENT_REGULATION    = 2'h0,
		CONSTANT_POWER_REGULATION      = 2'h1,
		CONSTANT_RESISTANCE_REGULATION = 2'h2
	} bds_regmode_t;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_LOAD = 4'h2,
		ST_RUN  = 4'h4,
		ST_STOP = 4'h8
	} bds_state_t;

	typedef enum logic [2:0] {
		WHY_NONE   = 3'h0,
		WHY_MANUAL = 3'h1,
		WHY_TIME   = 3'h2,
		WHY_CAP    = 3'h3,
		WHY_ALARM  = 3'h4,
		WHY_THRESH = 3'h5
	} bds_why_t;
endpackage: bds_pkg

// ---- hw/bds_if.sv ----
`timescale 1ns/1ps
interface bds_tick_if;
	logic       clr;
	logic       run;
	logic       msTick;
	logic       secTick;
	logic [3:0] hours;
	logic [5:0] minutes;
	logic [5:0] seconds;
	logic [9:0] millis;
	modport tb(input clr, run,
		output msTick, secTick, hours, minutes, seconds, millis);
	modport ctl(output clr, run,
		input msTick, secTick, hours, minutes, seconds, millis);
endinterface: bds_tick_if

interface bds_mem_if;
	logic        we;
	logic [2:0]  waddr;
	logic [2:0]  raddr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	modport mem(input we, waddr, raddr, wdata, output rdata);
	modport ctl(output we, waddr, raddr, wdata, input rdata);
endinterface: bds_mem_if

// ---- hw/bds_cfg_mem.sv ----
`timescale 1ns/1ps
// Two modes of four words each; read data is registered.
module bds_cfg_mem (
	input wire logic mclk,
	input wire logic resetn,
	bds_mem_if.mem   port
);
	typedef struct packed {
		logic [7:0][31:0] words;
		logic [31:0]      rdata;
	} bds_mem_t;

	bds_mem_t r;
	bds_mem_t next_r;

	always_comb begin
		next_r = r;
		next_r.rdata = r.words[port.raddr];
		if (port.we) begin
			next_r.words[port.waddr] = port.wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign port.rdata = r.rdata;
endmodule: bds_cfg_mem

// ---- hw/bds_timebase.sv ----
`timescale 1ns/1ps
module bds_timebase import bds_pkg::*; #(
	parameter int TICK_CYCLES = MS_CYCLES
) (
	input wire logic mclk,
	input wire logic resetn,
	bds_tick_if.tb   tick
);
	typedef struct packed {
		logic [14:0] pre;
		logic [9:0]  ms;
		logic [5:0]  s;
		logic [5:0]  m;
		logic [3:0]  h;
		logic        msT;
		logic        secT;
	} bds_tb_t;

	bds_tb_t r;
	bds_tb_t next_r;

	always_comb begin
		next_r = r;
		next_r.msT = 1'b0;
		next_r.secT = 1'b0;
		if (tick.clr) begin
			next_r = '0;
		end else if (tick.run) begin
			next_r.pre = r.pre + 15'h0001;
			if (r.pre == 15'(TICK_CYCLES - 1)) begin
				next_r.pre = '0;
				next_r.msT = 1'b1;
				next_r.ms = r.ms + 10'h001;
				if (r.ms == MS_LAST) begin
					next_r.ms = '0;
					next_r.secT = 1'b1;
					next_r.s = r.s + 6'h01;
					if (r.s == SIXTY_LAST) begin
						next_r.s = '0;
						next_r.m = r.m + 6'h01;
						if (r.m == SIXTY_LAST) begin
							next_r.m = '0;
							next_r.h = r.h + 4'h1;
						end
					end
				end
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign tick.msTick = r.msT;
	assign tick.secTick = r.secT;
	assign tick.hours = r.h;
	assign tick.minutes = r.m;
	assign tick.seconds = r.s;
	assign tick.millis = r.ms;

	AST_SEC_WRAP: assert property (@(posedge mclk) disable iff (!resetn)
		r.secT |-> (r.ms == 10'h000 && r.msT))
		else $error("Second tick without millisecond wrap.");
endmodule: bds_timebase

// ---- hw/bds_supervisor.sv ----
// The Wishbone interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
module bds_supervisor import bds_pkg::*; #(
	parameter int TICK_CYCLES = MS_CYCLES
) (
	input  wire logic        mclk,
	input  wire logic        resetn,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output wire logic [31:0] dat_o,
	output wire logic        ack_o,
	input  wire logic [15:0] batteryVoltage,
	input  wire logic [15:0] loadCurrent,
	input  wire logic [15:0] loadPower,
	input  wire logic [1:0]  regMode,
	input  wire logic        inputOffAlarm,
	input  wire logic        stickPresent,
	output wire logic        inputEnable,
	output wire logic        limitMessage,
	output wire logic        logActive,
	output wire logic        logFileReady,
	output wire logic        logStrobe,
	output wire logic        logHeader,
	output wire logic [15:0] logVoltage,
	output wire logic [15:0] logCurrent,
	output wire logic [15:0] logPower,
	output wire logic [39:0] logCapacity,
	output wire logic [39:0] logEnergy,
	output wire logic [25:0] logTime
);
	typedef struct packed {
		bds_state_t  st;
		logic        ack;
		logic [31:0] dat;
		logic        memWait;
		logic        armed;
		logic        mode;
		logic        runMode;
		logic [2:0]  ldIdx;
		logic [15:0] thr;
		logic [15:0] tLim;
		logic [23:0] cLim;
		logic [1:0]  tAct;
		logic [1:0]  cAct;
		logic [3:0]  ivl;
		logic [15:0] secs;
		logic [39:0] cap;
		logic [39:0] eng;
		logic        tHit;
		logic        cHit;
		logic        sigTime;
		logic        sigCap;
		bds_why_t    why;
		logic        logAct;
		logic        fileReady;
		logic [13:0] logMs;
		logic        logStb;
		logic        logHdr;
		logic [15:0] lV;
		logic [15:0] lI;
		logic [15:0] lP;
		logic [39:0] lCap;
		logic [39:0] lEng;
		logic [25:0] lTime;
		logic [1:0]  alSync;
		logic [1:0]  stSync;
	} bds_top_t;

	bds_top_t   r;
	bds_top_t   next_r;
	bds_tick_if tick();
	bds_mem_if  memBus();

	logic        req;
	logic        isCfg;
	logic        wrAck;
	logic        ctrlWr;
	logic        stopCmd;
	logic        alarm;
	logic [39:0] capLimit;
	logic        timeReached;
	logic        capReached;
	logic [31:0] rd;

	function automatic logic [13:0] ivlMs(input logic [3:0] code);
		logic [13:0] v;
		v = IVL_10S_MS;
		if (code <= IVL_CODE_1S) begin
			v = 14'(IVL_STEP_MS * ({10'h000, code} + 14'h0001));
		end else if (code == IVL_CODE_5S) begin
			v = IVL_5S_MS;
		end
		return v;
	endfunction: ivlMs

	bds_timebase #(.TICK_CYCLES(TICK_CYCLES)) uTime (
		.mclk   (mclk),
		.resetn (resetn),
		.tick   (tick.tb)
	);

	bds_cfg_mem uMem (
		.mclk   (mclk),
		.resetn (resetn),
		.port   (memBus.mem)
	);

	assign req = cyc_i && stb_i && !r.ack;
	assign isCfg = (adr_i[7:5] == A_CFG_TAG);
	// Writes take effect on the edge that completes the handshake.
	assign wrAck = cyc_i && stb_i && we_i && r.ack && (sel_i == SEL_ALL);
	assign ctrlWr = wrAck && (adr_i == A_CTRL);
	assign stopCmd = ctrlWr && dat_i[CTRL_STOP];
	assign alarm = r.alSync[1];
	assign capLimit = 40'(r.cLim) * 40'(MAS_PER_CAH);
	// A zero limit disables that limit instead of ending at once.
	assign timeReached = (r.tLim != 16'h0000) && (r.secs >= r.tLim);
	assign capReached = (r.cLim != 24'h000000) && (r.cap >= capLimit);

	// each mode owns its own four configuration words.
	assign memBus.we = wrAck && isCfg;
	assign memBus.waddr = adr_i[4:2];
	assign memBus.wdata = dat_i;
	assign memBus.raddr = (r.st == ST_LOAD) ?
		{r.runMode, r.ldIdx[1:0]} : adr_i[4:2];
	assign tick.clr = (r.st == ST_LOAD);
	assign tick.run = (r.st == ST_RUN);

	always_comb begin
		case (adr_i)
			A_CTRL: rd = {27'h0, r.mode, 4'h0};
			A_STAT: rd = {18'h0, r.stSync[1], r.runMode, r.why,
				r.sigCap, r.sigTime, r.fileReady, r.logAct,
				r.armed, r.st};
			A_SECS: rd = {16'h0, r.secs};
			A_HMS: rd = {4'h0, regMode, tick.hours, tick.minutes,
				tick.seconds, tick.millis};
			A_CAPL: rd = r.cap[31:0];
			A_CAPH: rd = {24'h0, r.cap[39:32]};
			A_ENGL: rd = r.eng[31:0];
			A_ENGH: rd = {24'h0, r.eng[39:32]};
			default: rd = 32'h00000000;
		endcase
	end

	always_comb begin
		next_r = r;
		next_r.ack = 1'b0;
		next_r.logStb = 1'b0;
		next_r.alSync = {r.alSync[0], inputOffAlarm};
		next_r.stSync = {r.stSync[0], stickPresent};
		if (!(cyc_i && stb_i)) begin
			next_r.memWait = 1'b0;
		end
		if (req) begin
			if (!isCfg || we_i) begin
				next_r.ack = 1'b1;
				next_r.dat = rd;
			end else if (r.memWait) begin
				next_r.ack = 1'b1;
				next_r.memWait = 1'b0;
				next_r.dat = memBus.rdata;
			end else if (r.st != ST_LOAD) begin
				next_r.memWait = 1'b1;
			end
		end
		if (ctrlWr) begin
			next_r.mode = dat_i[CTRL_MODE];
			if (dat_i[CTRL_ARM]) begin
				next_r.armed = 1'b1;
			end
		end
		case (r.st)
			ST_IDLE, ST_STOP: begin
				if (ctrlWr && dat_i[CTRL_START] && r.armed) begin
					next_r.st = ST_LOAD;
					next_r.runMode = dat_i[CTRL_MODE];
					next_r.ldIdx = '0;
					next_r.secs = '0;
					next_r.cap = '0;
					next_r.eng = '0;
					next_r.tHit = 1'b0;
					next_r.cHit = 1'b0;
					next_r.sigTime = 1'b0;
					next_r.sigCap = 1'b0;
					next_r.why = WHY_NONE;
					next_r.fileReady = 1'b0;
					next_r.logMs = '0;
				end
			end
			ST_LOAD: begin
				next_r.ldIdx = r.ldIdx + 3'h1;
				case (r.ldIdx)
					CFG_THR: next_r.thr = memBus.rdata[15:0];
					CFG_TLIM: next_r.tLim = memBus.rdata[15:0];
					CFG_CLIM: next_r.cLim = memBus.rdata[23:0];
					CFG_ACT: begin
						next_r.tAct = memBus.rdata[ACT_TIME_LSB +: 2];
						next_r.cAct = memBus.rdata[ACT_CAP_LSB +: 2];
						next_r.ivl = memBus.rdata[ACT_IVL_LSB +: 4];
						next_r.st = ST_RUN;
						if (memBus.rdata[ACT_LOG] && r.stSync[1]) begin
							next_r.logAct = 1'b1;
							next_r.logStb = 1'b1;
							next_r.logHdr = 1'b1;
							next_r.lV = r.thr;
							next_r.lI = r.tLim;
							next_r.lP = {15'h0, r.runMode};
							next_r.lCap = 40'(r.cLim);
							next_r.lEng = '0;
							next_r.lTime = '0;
						end
					end
					default: next_r.ldIdx = r.ldIdx + 3'h1;
				endcase
				if (stopCmd) begin
					next_r.st = ST_STOP;
					next_r.why = WHY_MANUAL;
					next_r.logAct = 1'b0;
				end
			end
			ST_RUN: begin
				if (tick.secTick) begin
					next_r.secs = r.secs + 16'h0001;
					next_r.cap = r.cap + 40'(loadCurrent);
					next_r.eng = r.eng + 40'(loadPower);
				end
				if (r.logAct && tick.msTick) begin
					next_r.logMs = r.logMs + 14'h0001;
					if (r.logMs + 14'h0001 >= ivlMs(r.ivl)) begin
						next_r.logMs = '0;
						next_r.logStb = 1'b1;
						next_r.logHdr = 1'b0;
						next_r.lV = batteryVoltage;
						next_r.lI = loadCurrent;
						next_r.lP = loadPower;
						next_r.lCap = r.cap;
						next_r.lEng = r.eng;
						next_r.lTime = {tick.hours, tick.minutes,
							tick.seconds, tick.millis};
					end
				end
				if (timeReached && !r.tHit) begin
					next_r.tHit = 1'b1;
					next_r.sigTime = (r.tAct == LIM_SIGNAL);
				end
				if (capReached && !r.cHit) begin
					next_r.cHit = 1'b1;
					next_r.sigCap = (r.cAct == LIM_SIGNAL);
				end
				// Priority: operator, alarm, threshold, time, capacity.
				if (stopCmd) begin
					next_r.why = WHY_MANUAL;
				end else if (alarm) begin
					next_r.why = WHY_ALARM;
				end else if (batteryVoltage <= r.thr) begin
					next_r.why = WHY_THRESH;
				end else if (timeReached &&
					r.tAct == LIMIT_ACTION_TERMINATE) begin
					next_r.why = WHY_TIME;
				end else if (capReached &&
					r.cAct == LIMIT_ACTION_TERMINATE) begin
					next_r.why = WHY_CAP;
				end
				if (next_r.why != WHY_NONE) begin
					next_r.st = ST_STOP;
					next_r.logAct = 1'b0;
					next_r.fileReady = r.logAct;
					// An automatic stop demands a fresh arm before restart.
					next_r.armed = stopCmd;
				end
			end
			default: next_r.st = ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.why <= WHY_NONE;
			r.armed <= RST_ARMED;
		end else begin
			r <= next_r;
		end
	end

	assign dat_o = r.dat;
	assign ack_o = r.ack;
	assign inputEnable = (r.st == ST_RUN);
	assign limitMessage = r.sigTime || r.sigCap;
	assign logActive = r.logAct;
	assign logFileReady = r.fileReady;
	assign logStrobe = r.logStb;
	assign logHeader = r.logHdr;
	assign logVoltage = r.lV;
	assign logCurrent = r.lI;
	assign logPower = r.lP;
	assign logCapacity = r.lCap;
	assign logEnergy = r.lEng;
	assign logTime = r.lTime;

	default clocking dc @(posedge mclk); endclocking
	default disable iff (!resetn);

	AST_ALARM_STOP: assert property (
		(r.st == ST_RUN && alarm && !stopCmd) |=>
		(r.st == ST_STOP && r.why == WHY_ALARM && !r.armed))
		else $error("Alarm did not end and disarm the run.");
	AST_THRESH_STOP: assert property (
		(r.st == ST_RUN && !alarm && !stopCmd &&
		batteryVoltage <= r.thr) |=> (r.st == ST_STOP && r.why == WHY_THRESH))
		else $error("Threshold did not end the run.");
	AST_NO_RESTART: assert property (
		(r.st == ST_STOP && !r.armed) |=> (r.st != ST_LOAD))
		else $error("Restart accepted while disarmed.");
	AST_MANUAL_STOP: assert property (
		(r.st == ST_RUN && stopCmd) |=>
		(r.st == ST_STOP && r.why == WHY_MANUAL && !inputEnable))
		else $error("Operator stop did not end the run.");
	AST_SEC_ACCUM: assert property (
		(r.st == ST_RUN && tick.secTick) |=>
		(r.cap == $past(r.cap) + 40'($past(loadCurrent))))
		else $error("Capacity not added on second tick.");
	AST_CAP_HOLD: assert property (
		(r.st == ST_RUN && !tick.secTick) |=> $stable(r.cap))
		else $error("Capacity changed between seconds.");
	AST_CLEAR_START: assert property (
		(r.st == ST_LOAD) |-> (r.secs == 16'h0000 && r.cap == 40'h0 &&
		r.eng == 40'h0))
		else $error("Accumulators not cleared at start.");
	AST_LOG_IN_RUN: assert property (
		(logStrobe && !logHeader) |-> ($past(r.st) == ST_RUN &&
		$past(r.logAct)))
		else $error("Record written outside an active log.");
	AST_SIGNAL_RUNS: assert property (
		(r.st == ST_RUN && timeReached && !r.tHit && r.tAct == LIM_SIGNAL &&
		!stopCmd && !alarm && batteryVoltage > r.thr && !capReached)
		|=> (r.sigTime && r.st == ST_RUN))
		else $error("Signal action did not flag and continue.");
	AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
		else $error("Bus acknowledge held longer than one cycle.");
endmodule: bds_supervisor

// ---- bench/bds_battery.sv ----
`timescale 1ns/1ps
// Battery on the DC input. The terminal voltage sags while current is drawn,
// so a threshold set just under the rest voltage is crossed once loaded.
module bds_battery (
	input  wire logic        mclk,
	input  wire logic        drawOn,
	input  wire logic [15:0] restVolts,
	input  wire logic [15:0] drawAmps,
	input  wire logic [15:0] drawWatts,
	output logic      [15:0] batteryVoltage,
	output logic      [15:0] loadCurrent,
	output logic      [15:0] loadPower
);
	always_ff @(posedge mclk) begin
		batteryVoltage <= drawOn ? restVolts - 16'h0010 : restVolts;
		loadCurrent    <= drawOn ? drawAmps : 16'h0000;
		loadPower      <= drawOn ? drawWatts : 16'h0000;
	end
endmodule: bds_battery

// ---- bench/battery_discharge_supervisor_tb_top.sv ----
`timescale 1ns/1ps
module battery_discharge_supervisor_tb_top import bds_pkg::*;;
	typedef struct packed {
		logic [7:0]  a;
		logic [3:0]  s;
		logic [31:0] d;
		logic [31:0] e;
	} bds_row_t;
	localparam int NR = 11;
	bds_row_t rows [NR] = '{
		'{8'h40, 4'hF, 32'h0000_1234, 32'h0000_1234},
		'{8'h50, 4'hF, 32'h0000_0ABC, 32'h0000_0ABC},
		'{8'h44, 4'hF, 32'h0000_0E10, 32'h0000_0E10},
		'{8'h54, 4'hF, 32'h0000_0005, 32'h0000_0005},
		'{8'h48, 4'hF, 32'h0098_967F, 32'h0098_967F},
		'{8'h58, 4'hF, 32'h0000_0001, 32'h0000_0001},
		'{8'h4C, 4'hF, 32'h0000_0B1E, 32'h0000_0B1E},
		'{8'h5C, 4'hF, 32'h0000_0915, 32'h0000_0915},
		'{8'h40, 4'h3, 32'h0000_FFFF, 32'h0000_1234},
		'{8'h60, 4'hF, 32'h0000_FFFF, 32'h0000_0000},
		'{8'h04, 4'hF, 32'hFFFF_FFFF, 32'h0000_0011}
	};
	logic        mclk = 1'b0;
	logic        resetn = 1'b0;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [3:0]  sel = 4'h0;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic        ack;
	logic [1:0]  regMode = 2'h0;
	logic        alarm = 1'b0;
	logic        stick = 1'b0;
	logic [15:0] restVolts = 16'h2000;
	logic [15:0] drawAmps = 16'h0100;
	logic [15:0] drawWatts = 16'h0020;
	logic [15:0] bv, lc, lp, logVoltage, logCurrent, logPower;
	logic [39:0] logCapacity, logEnergy;
	logic [25:0] logTime;
	logic        inputEnable, limitMessage, logActive, logFileReady;
	logic        logStrobe, logHeader;
	logic [15:0] hV, hI, hP;
	logic [39:0] hC, hE;
	logic [25:0] hT;
	logic [15:0] rI, rP;
	logic [39:0] recEng[$];
	logic [25:0] recTime[$];
	logic [39:0] recCap[$];
	logic [15:0] recV[$];
	int          nHdr = 0;
	int          n_fail = 0;
	int          num_checks = 0;

	always #25 mclk = ~mclk;

	bds_battery bat_u (.mclk(mclk), .drawOn(inputEnable),
		.restVolts(restVolts), .drawAmps(drawAmps), .drawWatts(drawWatts),
		.batteryVoltage(bv), .loadCurrent(lc), .loadPower(lp));

	bds_supervisor #(.TICK_CYCLES(4)) dut_u (.mclk(mclk), .resetn(resetn),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
		.dat_i(wdat), .dat_o(rdat), .ack_o(ack), .batteryVoltage(bv),
		.loadCurrent(lc), .loadPower(lp), .regMode(regMode),
		.inputOffAlarm(alarm), .stickPresent(stick),
		.inputEnable(inputEnable), .limitMessage(limitMessage),
		.logActive(logActive), .logFileReady(logFileReady),
		.logStrobe(logStrobe), .logHeader(logHeader),
		.logVoltage(logVoltage), .logCurrent(logCurrent),
		.logPower(logPower), .logCapacity(logCapacity),
		.logEnergy(logEnergy), .logTime(logTime));

	always @(posedge mclk) begin
		if (logStrobe === 1'b1 && logHeader === 1'b1) begin
			nHdr <= nHdr + 1;
			hV <= logVoltage;
			hI <= logCurrent;
			hP <= logPower;
			hC <= logCapacity;
			hE <= logEnergy;
			hT <= logTime;
		end else if (logStrobe === 1'b1) begin
			recCap.push_back(logCapacity);
			recV.push_back(logVoltage);
			recEng.push_back(logEnergy);
			recTime.push_back(logTime);
			rI <= logCurrent;
			rP <= logPower;
		end
	end

	task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask: chk

	task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s,
			input logic [31:0] d, output logic [31:0] q);
		int k;
		k = 0;
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		wdat <= d;
		do begin
			@(posedge mclk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		chk(k < 20, 1'b1);
	endtask: wb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, a, SEL_ALL, d, q);
	endtask: wr

	task automatic rd(input logic [7:0] a, output logic [31:0] q);
		wb(1'b0, a, SEL_ALL, 32'h0000_0000, q);
	endtask: rd

	// Base is 8'h00 for the first test mode and 8'h10 for the second.
	task automatic cfg(input logic [7:0] b, input logic [31:0] t, l, c, x);
		wr(8'h40 + b, t);
		wr(8'h44 + b, l);
		wr(8'h48 + b, c);
		wr(8'h4C + b, x);
	endtask: cfg

	// Bounded wait for the DC input to reach the given state.
	task automatic waitie(input logic v, input int n);
		int k;
		k = 0;
		while (inputEnable !== v && k < n) begin
			@(posedge mclk);
			k++;
		end
		chk(inputEnable, v);
	endtask: waitie

	task automatic conclude();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask: conclude

	initial begin
		#2500000;
		n_fail++;
		conclude();
	end

	initial begin
		logic [31:0] q;
		repeat (4) @(posedge mclk);
		resetn <= 1'b1;
		@(posedge mclk);
		chk({inputEnable, logStrobe, logActive}, 3'h0);
		for (int i = 0; i < NR; i++)
			wb(1'b1, rows[i].a, rows[i].s, rows[i].d, q);
		for (int i = 0; i < NR; i++) begin
			rd(rows[i].a, q);
			chk(q, rows[i].e);
		end
		// Time limit with terminate, logging at 500 ms.
		stick <= 1'b1;
		cfg(8'h00, 32'h1000, 32'h0002, 32'h0000, 32'h0412);
		wr(A_CTRL, 32'h0000_0001);
		waitie(1'b1, 10);
		repeat (4) @(posedge mclk);
		chk(logActive, 1'b1);
		chk({nHdr[7:0], hV, hI}, {8'h01, 16'h1000, 16'h0002});
		chk({hP, hC[15:0]}, 32'h0000_0000);
		chk(hE, 40'h0);
		chk(hT, 26'h0);
		waitie(1'b0, 9000);
		rd(A_STAT, q);
		chk(q[11:0], 12'h448);
		rd(A_SECS, q);
		chk(q, 32'h0000_0002);
		rd(A_CAPL, q);
		chk(q, 32'h0000_0200);
		rd(A_ENGL, q);
		chk(q, 32'h0000_0040);
		chk(recCap.size() >= 3, 1'b1);
		chk(recCap[0], 40'h0);
		chk(recCap[2], 40'h100);
		chk(recV[0], 16'h1FF0);
		chk(recEng[2], 40'h20);
		chk(recTime[0], 26'h1F4);
		chk(recTime[1], 26'h400);
		chk({rI, rP}, 32'h0100_0020);
		chk({logFileReady, logActive}, 2'h2);
		wr(A_CTRL, 32'h0000_0001);
		rd(A_STAT, q);
		chk(q[3:0], 4'h8);
		// Second mode: threshold stop, no stick so no log.
		stick <= 1'b0;
		restVolts <= 16'h0C10;
		cfg(8'h10, 32'h0800, 32'h0000, 32'h0000, 32'h0010);
		wr(A_CTRL, 32'h0000_0004);
		wr(A_CTRL, 32'h0000_0011);
		waitie(1'b1, 10);
		repeat (50) @(posedge mclk);
		chk({logActive, logFileReady}, 2'h0);
		chk(nHdr, 1);
		restVolts <= 16'h0810;
		waitie(1'b0, 6);
		rd(A_STAT, q);
		chk(q[12:9], 4'hD);
		// Signal action, then operator stop.
		// Both limits signal; capacity is reached one second after time.
		restVolts <= 16'h2000;
		drawAmps <= 16'h4650;
		cfg(8'h10, 32'h0000, 32'h0001, 32'h0001, 32'h0005);
		wr(A_CTRL, 32'h0000_0004);
		wr(A_CTRL, 32'h0000_0011);
		waitie(1'b1, 10);
		repeat (4400) @(posedge mclk);
		chk({limitMessage, inputEnable}, 2'h3);
		rd(A_STAT, q);
		chk(q[8:7], 2'h1);
		repeat (4000) @(posedge mclk);
		wr(A_CTRL, 32'h0000_0002);
		waitie(1'b0, 3);
		rd(A_STAT, q);
		chk({q[11:9], q[7], q[4]}, 5'h07);
		chk(q[8], 1'b1);
		// Manual stop keeps the arm, so a plain start runs again.
		wr(A_CTRL, 32'h0000_0011);
		waitie(1'b1, 10);
		chk(limitMessage, 1'b0);
		alarm <= 1'b1;
		waitie(1'b0, 6);
		rd(A_STAT, q);
		chk(q[11:9], 3'h4);
		alarm <= 1'b0;
		// Capacity terminate at one unit, time limit with no action.
		drawAmps <= 16'h4650;
		regMode <= 2'h2;
		cfg(8'h00, 32'h0000, 32'h0001, 32'h0001, 32'h0008);
		wr(A_CTRL, 32'h0000_0004);
		wr(A_CTRL, 32'h0000_0001);
		waitie(1'b1, 10);
		repeat (6000) @(posedge mclk);
		chk({inputEnable, limitMessage}, 2'h2);
		waitie(1'b0, 3000);
		rd(A_STAT, q);
		chk(q[11:9], 3'h3);
		rd(A_HMS, q);
		chk({q[27:26], q[15:10]}, 8'h82);
		rd(A_CAPL, q);
		chk(q, {16'h0000, MAS_PER_CAH});
		rd(A_CAPH, q);
		chk(q, 32'h0000_0000);
		conclude();
	end
endmodule: battery_discharge_supervisor_tb_top
